// file: adccfg_map.svh
// register offsets, field positions, write masks and reset values
`ifndef ADCCFG_MAP_SVH
`define ADCCFG_MAP_SVH
`define ADCCFG_BASE_HI        5'h06
`define ADCCFG_OFS_RESET_SPD  8'h30
`define ADCCFG_OFS_PWR_REF    8'h31
`define ADCCFG_OFS_OUT_IF     8'h32
`define ADCCFG_OFS_FMT_PAT    8'h33
`define ADCCFG_OFS_PAT_OFSA   8'h34
`define ADCCFG_OFS_GAIN_A     8'h35
`define ADCCFG_OFS_TEST_PED   8'h36
`define ADCCFG_OFS_OFS_GAIN_B 8'h37
`define ADCCFG_IDX_RESET_SPD  3'h0
`define ADCCFG_IDX_PWR_REF    3'h1
`define ADCCFG_IDX_OUT_IF     3'h2
`define ADCCFG_IDX_FMT_PAT    3'h3
`define ADCCFG_IDX_PAT_OFSA   3'h4
`define ADCCFG_IDX_GAIN_A     3'h5
`define ADCCFG_IDX_TEST_PED   3'h6
`define ADCCFG_IDX_OFS_GAIN_B 3'h7
`define ADCCFG_MASK0          16'h0481
`define ADCCFG_MASK1          16'h0f62
`define ADCCFG_MASK2          16'hfc80
`define ADCCFG_MASK3          16'hff46
`define ADCCFG_MASK4          16'h403f
`define ADCCFG_MASK5          16'h7fff
`define ADCCFG_MASK6          16'h3f07
`define ADCCFG_MASK7          16'hff40
`define ADCCFG_RESET_VAL      16'h0000
`define ADCCFG_DIRTY_NONE     8'h00
`define ADCCFG_DIRTY_REG0     8'h01
`define ADCCFG_BIT_READBACK   0
`define ADCCFG_BIT_SWRESET    7
`define ADCCFG_BIT_LOWSPEED   10
`define ADCCFG_BIT_STANDBY    1
`define ADCCFG_REF_LSB        5
`define ADCCFG_PWR_LSB        8
`define ADCCFG_BIT_LVDS       7
`define ADCCFG_FALL_LSB       10
`define ADCCFG_RISE_LSB       13
`define ADCCFG_FMT_LSB        1
`define ADCCFG_BIT_INDEP      6
`define ADCCFG_PATLO_LSB      8
`define ADCCFG_PATHI_LSB      0
`define ADCCFG_BIT_OFSEN_A    14
`define ADCCFG_BIT_OFSEN_B    6
`define ADCCFG_TCA_LSB        0
`define ADCCFG_TCB_LSB        8
`define ADCCFG_CGA_LSB        4
`define ADCCFG_CGB_LSB        12
`define ADCCFG_FINE_LSB       8
`define ADCCFG_TEST_LSB       0
`define ADCCFG_PED_LSB        8
`define ADCCFG_PWR_PINS       4'h0
`define ADCCFG_PWR_NORMAL     4'h8
`define ADCCFG_PWR_OFF_B      4'h9
`define ADCCFG_PWR_OFF_A      4'ha
`define ADCCFG_PWR_OFF_AB     4'hb
`define ADCCFG_PWR_GLOBAL     4'hc
`define ADCCFG_PWR_STBY_B     4'hd
`define ADCCFG_PWR_STBY_A     4'he
`define ADCCFG_EDGE_P4        3'h5
`define ADCCFG_EDGE_M6        3'h6
`define ADCCFG_EDGE_M4        3'h7
`define ADCCFG_SHIFT_P4       5'h04
`define ADCCFG_SHIFT_M6       5'h1a
`define ADCCFG_SHIFT_M4       5'h1c
`define ADCCFG_SHIFT_ZERO     5'h00
`define ADCCFG_FMT_TWOS       2'h2
`define ADCCFG_FMT_OFFBIN     2'h3
`define ADCCFG_TC_LOG2_BASE   5'h12
`define ADCCFG_TC_CODE_MAX    4'hb
`define ADCCFG_CG_CODE_MAX    4'hc
`define ADCCFG_FRAME_BITS     24
`define ADCCFG_FRAME_LAST     5'h17
`endif

// file: adccfg_pkg.sv
// types shared by the converter configuration bank
package adccfg_pkg;
  typedef enum logic [1:0]
  {
    ADCCFG_IDLE  = 2'b00,
    ADCCFG_SHIFT = 2'b01,
    ADCCFG_GAP   = 2'b11
  } adccfg_state_e;
  typedef logic [15:0] adccfg_word_t;
endpackage

// file: adccfg_bank.sv
// converter configuration register bank with serial update to the converter
`include "adccfg_map.svh"
module adccfg_bank
#(
  parameter logic [7:0] SCLK_HALF = 8'h02
)
(
  // clock, reset, enable
  input  wire logic                MCLK,
  input  wire logic                RST,
  input  wire logic                CE,
  // host register port
  input  wire logic [7:0]          REG_ADDR,
  input  wire logic                REG_WR,
  input  wire logic                REG_RD,
  input  wire adccfg_pkg::adccfg_word_t REG_WDATA,
  output adccfg_pkg::adccfg_word_t REG_RDATA,
  // converter serial configuration port
  output logic                     CFG_SCLK,
  output logic                     CFG_SEN_N,
  output logic                     CFG_SDATA,
  output logic                     CFG_BUSY,
  // decoded converter settings
  output logic                     SERIAL_READBACK_EN,
  output logic                     LOW_SPEED,
  output logic                     STANDBY_BOTH,
  output logic [1:0]               REF_SEL,
  output logic                     PWR_PIN_CTRL,
  output logic                     PWR_NORMAL,
  output logic                     OUT_OFF_A,
  output logic                     OUT_OFF_B,
  output logic                     GLOBAL_PD,
  output logic                     STBY_A,
  output logic                     STBY_B,
  output logic [4:0]               FALL_SHIFT,
  output logic [4:0]               RISE_SHIFT,
  output logic                     LVDS_MODE,
  output logic                     TWOS_COMP,
  output logic                     OFFSET_BIN,
  output logic                     INDEP_CTRL,
  output logic                     OFS_EN_A,
  output logic                     OFS_EN_B,
  output logic [4:0]               TC_LOG2_A,
  output logic [4:0]               TC_LOG2_B,
  output logic [3:0]               COARSE_A,
  output logic [3:0]               COARSE_B,
  output logic [6:0]               FINE_GAIN,
  output logic [2:0]               TEST_MODE,
  output logic [13:0]              CUSTOM_PATTERN,
  output logic [5:0]               PEDESTAL
);
  import adccfg_pkg::*;

  if (SCLK_HALF == 8'h00)
  begin : g_bad_div
    $error("SCLK_HALF must be at least one");
  end

  adccfg_word_t  regs [8];
  logic [7:0]    dirty;
  logic          swreset_pend;
  adccfg_state_e state;
  logic [23:0]   shreg;
  logic [4:0]    bit_cnt;
  logic [7:0]    half_cnt;
  logic          sclk;
  logic          sen_n;

  wire           hit      = (REG_ADDR[7:3] == `ADCCFG_BASE_HI);
  wire [2:0]     idx      = REG_ADDR[2:0];
  wire           wr_hit   = REG_WR && hit;
  wire           swreset  = wr_hit && (idx == `ADCCFG_IDX_RESET_SPD)
                            && REG_WDATA[`ADCCFG_BIT_SWRESET];

  // reserved bits never store, so they read back zero
  function automatic adccfg_word_t wmask(input logic [2:0] i);
    case (i)
      `ADCCFG_IDX_RESET_SPD:  wmask = `ADCCFG_MASK0;
      `ADCCFG_IDX_PWR_REF:    wmask = `ADCCFG_MASK1;
      `ADCCFG_IDX_OUT_IF:     wmask = `ADCCFG_MASK2;
      `ADCCFG_IDX_FMT_PAT:    wmask = `ADCCFG_MASK3;
      `ADCCFG_IDX_PAT_OFSA:   wmask = `ADCCFG_MASK4;
      `ADCCFG_IDX_GAIN_A:     wmask = `ADCCFG_MASK5;
      `ADCCFG_IDX_TEST_PED:   wmask = `ADCCFG_MASK6;
      default:                wmask = `ADCCFG_MASK7;
    endcase
  endfunction

  // output clock edge code to signed shift in 26ths of the sample period
  function automatic logic [4:0] edge_shift(input logic [2:0] c);
    case (c)
      `ADCCFG_EDGE_P4: edge_shift = `ADCCFG_SHIFT_P4;
      `ADCCFG_EDGE_M6: edge_shift = `ADCCFG_SHIFT_M6;
      `ADCCFG_EDGE_M4: edge_shift = `ADCCFG_SHIFT_M4;
      default:         edge_shift = `ADCCFG_SHIFT_ZERO;
    endcase
  endfunction

  // lowest dirty register is sent first
  logic       any_dirty;
  logic [2:0] pick;
  always_comb
  begin
    any_dirty = 1'b0;
    pick      = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (dirty[i])
      begin
        any_dirty = 1'b1;
        pick      = 3'(i);
      end
    end
  end

  wire launch    = (state == ADCCFG_IDLE) && any_dirty;
  wire half_done = (half_cnt == SCLK_HALF - 8'h01);
  wire fall_now  = (state == ADCCFG_SHIFT) && half_done && sclk;
  wire last_bit  = (bit_cnt == `ADCCFG_FRAME_LAST);

  // converter gets its reset bit once, then the bank sits at defaults
  wire [15:0] tx_word = (pick == `ADCCFG_IDX_RESET_SPD && swreset_pend)
                      ? (regs[pick] | (16'h0001 << `ADCCFG_BIT_SWRESET))
                      : regs[pick];
  wire [7:0]  clr_vec = launch ? (8'h01 << pick) : `ADCCFG_DIRTY_NONE;
  wire [7:0]  set_vec = wr_hit ? (8'h01 << idx) : `ADCCFG_DIRTY_NONE;

  // a new write wins over the launch that clears the same dirty bit
  wire [7:0]  next_dirty = swreset ? `ADCCFG_DIRTY_REG0
                         : ((dirty & ~clr_vec) | set_vec);

  // register storage
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      for (int i = 0; i < 8; i++)
        regs[i] <= `ADCCFG_RESET_VAL;
      dirty        <= `ADCCFG_DIRTY_NONE;
      swreset_pend <= 1'b0;
    end
    else if (CE)
    begin
      if (swreset)
      begin
        for (int i = 0; i < 8; i++)
          regs[i] <= `ADCCFG_RESET_VAL;
      end
      else if (wr_hit)
        regs[idx] <= REG_WDATA & wmask(idx);
      dirty <= next_dirty;
      if (swreset)
        swreset_pend <= 1'b1;
      else if (launch && pick == `ADCCFG_IDX_RESET_SPD)
        swreset_pend <= 1'b0;
    end
  end

  // read port: one cycle latency, unmapped reads zero
  always_ff @(posedge MCLK)
  begin
    if (RST)
      REG_RDATA <= `ADCCFG_RESET_VAL;
    else if (CE && REG_RD)
      REG_RDATA <= hit ? regs[idx] : `ADCCFG_RESET_VAL;
  end

  // serial frame: 8-bit register index then 16 data bits, msb first;
  // data changes on falling sclk so the converter samples on rising
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      state    <= ADCCFG_IDLE;
      shreg    <= 24'h000000;
      bit_cnt  <= 5'h00;
      half_cnt <= 8'h00;
      sclk     <= 1'b0;
      sen_n    <= 1'b1;
    end
    else if (CE)
    begin
      case (state)
        ADCCFG_IDLE:
        begin
          sclk     <= 1'b0;
          half_cnt <= 8'h00;
          bit_cnt  <= 5'h00;
          if (launch)
          begin
            shreg <= {5'h00, pick, tx_word};
            state <= ADCCFG_SHIFT;
            sen_n <= 1'b0;
          end
        end
        ADCCFG_SHIFT:
        begin
          half_cnt <= half_done ? 8'h00 : half_cnt + 8'h01;
          if (half_done)
            sclk <= ~sclk;
          if (fall_now)
          begin
            shreg   <= {shreg[22:0], 1'b0};
            bit_cnt <= bit_cnt + 5'h01;
            if (last_bit)
            begin
              state <= ADCCFG_GAP;
              sen_n <= 1'b1;
            end
          end
        end
        ADCCFG_GAP:
        begin
          // enable stays high one half period plus the idle cycle between frames
          half_cnt <= half_done ? 8'h00 : half_cnt + 8'h01;
          if (half_done)
            state <= ADCCFG_IDLE;
        end
        default:
        begin
          state <= ADCCFG_IDLE;
          sen_n <= 1'b1;
        end
      endcase
    end
  end

  assign CFG_SCLK  = sclk;
  // enable has its own flop: a state decode could glitch on gap to idle
  assign CFG_SEN_N = sen_n;
  assign CFG_SDATA = shreg[23];
  assign CFG_BUSY  = (state != ADCCFG_IDLE) || (dirty != `ADCCFG_DIRTY_NONE);

  // decoded settings straight from the register flops
  wire [15:0] r0 = regs[`ADCCFG_IDX_RESET_SPD];
  wire [15:0] r1 = regs[`ADCCFG_IDX_PWR_REF];
  wire [15:0] r2 = regs[`ADCCFG_IDX_OUT_IF];
  wire [15:0] r3 = regs[`ADCCFG_IDX_FMT_PAT];
  wire [15:0] r4 = regs[`ADCCFG_IDX_PAT_OFSA];
  wire [15:0] r5 = regs[`ADCCFG_IDX_GAIN_A];
  wire [15:0] r6 = regs[`ADCCFG_IDX_TEST_PED];
  wire [15:0] r7 = regs[`ADCCFG_IDX_OFS_GAIN_B];
  wire [3:0]  pwr = r1[`ADCCFG_PWR_LSB +: 4];
  wire [3:0]  tca = r5[`ADCCFG_TCA_LSB +: 4];
  wire [3:0]  tcb = r7[`ADCCFG_TCB_LSB +: 4];
  wire [3:0]  cga = r5[`ADCCFG_CGA_LSB +: 4];
  wire [3:0]  cgb = r7[`ADCCFG_CGB_LSB +: 4];
  wire [1:0]  fmt = r3[`ADCCFG_FMT_LSB +: 2];

  assign SERIAL_READBACK_EN = r0[`ADCCFG_BIT_READBACK];
  assign LOW_SPEED    = r0[`ADCCFG_BIT_LOWSPEED];
  assign STANDBY_BOTH = r1[`ADCCFG_BIT_STANDBY];
  assign REF_SEL      = r1[`ADCCFG_REF_LSB +: 2];
  assign PWR_PIN_CTRL = (pwr == `ADCCFG_PWR_PINS);
  assign PWR_NORMAL   = (pwr == `ADCCFG_PWR_NORMAL);
  assign OUT_OFF_B    = (pwr == `ADCCFG_PWR_OFF_B)
                     || (pwr == `ADCCFG_PWR_OFF_AB);
  assign OUT_OFF_A    = (pwr == `ADCCFG_PWR_OFF_A)
                     || (pwr == `ADCCFG_PWR_OFF_AB);
  assign GLOBAL_PD    = (pwr == `ADCCFG_PWR_GLOBAL);
  assign STBY_B       = (pwr == `ADCCFG_PWR_STBY_B);
  assign STBY_A       = (pwr == `ADCCFG_PWR_STBY_A);
  assign FALL_SHIFT   = edge_shift(r2[`ADCCFG_FALL_LSB +: 3]);
  assign RISE_SHIFT   = edge_shift(r2[`ADCCFG_RISE_LSB +: 3]);
  assign LVDS_MODE    = r2[`ADCCFG_BIT_LVDS];
  assign TWOS_COMP    = (fmt == `ADCCFG_FMT_TWOS);
  assign OFFSET_BIN   = (fmt == `ADCCFG_FMT_OFFBIN);
  assign INDEP_CTRL   = r3[`ADCCFG_BIT_INDEP];
  assign OFS_EN_A     = r4[`ADCCFG_BIT_OFSEN_A];
  // in common mode channel B follows channel A's correction enable
  assign OFS_EN_B     = INDEP_CTRL ? r7[`ADCCFG_BIT_OFSEN_B]
                                   : r4[`ADCCFG_BIT_OFSEN_A];
  // codes above the table saturate rather than run off the end
  assign TC_LOG2_A    = `ADCCFG_TC_LOG2_BASE + ((tca > `ADCCFG_TC_CODE_MAX)
                      ? {1'b0, `ADCCFG_TC_CODE_MAX} : {1'b0, tca});
  assign TC_LOG2_B    = `ADCCFG_TC_LOG2_BASE + ((tcb > `ADCCFG_TC_CODE_MAX)
                      ? {1'b0, `ADCCFG_TC_CODE_MAX} : {1'b0, tcb});
  assign COARSE_A     = (cga > `ADCCFG_CG_CODE_MAX) ? `ADCCFG_CG_CODE_MAX
                                                   : cga;
  assign COARSE_B     = (cgb > `ADCCFG_CG_CODE_MAX) ? `ADCCFG_CG_CODE_MAX
                                                   : cgb;
  assign FINE_GAIN    = r5[`ADCCFG_FINE_LSB +: 7];
  assign TEST_MODE    = r6[`ADCCFG_TEST_LSB +: 3];
  assign CUSTOM_PATTERN = {r4[`ADCCFG_PATHI_LSB +: 6],
                           r3[`ADCCFG_PATLO_LSB +: 8]};
  assign PEDESTAL     = r6[`ADCCFG_PED_LSB +: 6];
endmodule

// file: adccfg_conv_model.sv
// serial configuration port of the converter, as seen by the bank
module adccfg_conv_model
(
  // serial port
  input  wire logic sclk,
  input  wire logic sen_n,
  input  wire logic sdata,
  // captured settings and frame counts
  output logic [15:0] regs [8],
  output int          frames,
  output int          bad
);
  logic [23:0] sh;
  int          n;
  logic        act;
  initial
  begin
    frames = 0;
    bad = 0;
    act = 1'b0;
    foreach (regs[k])
      regs[k] = 16'h0000;
  end
  // a frame only counts from a falling enable, never from the reset edge
  always @(negedge sen_n)
  begin
    n = 0;
    act = 1'b1;
  end
  always @(posedge sclk)
    if (!sen_n)
    begin
      sh <= {sh[22:0], sdata};  // msb first
      n <= n + 1;
    end
  always @(posedge sen_n)
    if (act)
    begin
      frames <= frames + 1;
      if (n != 24 || sh[23:19] != 5'h00)
        bad <= bad + 1;
      else
        regs[sh[18:16]] <= sh[15:0];  // whole word applied
    end
endmodule

// file: adccfg_bank_props.sv
// assertions on the converter configuration bank ports
module adccfg_bank_props
(
  // clock, reset, register port
  input wire logic                     MCLK,
  input wire logic                     RST,
  input wire logic                     CE,
  input wire logic [7:0]               REG_ADDR,
  input wire logic                     REG_WR,
  input wire adccfg_pkg::adccfg_word_t REG_WDATA,
  // serial port and settings
  input wire logic                     CFG_SCLK,
  input wire logic                     CFG_SEN_N,
  input wire logic                     CFG_BUSY,
  input wire logic                     LOW_SPEED,
  input wire logic                     STANDBY_BOTH,
  input wire logic                     GLOBAL_PD,
  input wire logic                     LVDS_MODE,
  input wire logic                     TWOS_COMP,
  input wire logic [6:0]               FINE_GAIN,
  input wire logic [13:0]              CUSTOM_PATTERN
);
  import adccfg_pkg::*;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  logic w;
  assign w = CE & REG_WR;
  property p_swreset;
    w && REG_ADDR == 8'h30 && REG_WDATA[7] |=>
      FINE_GAIN == 7'h00 && CUSTOM_PATTERN == 14'h0000 && !LOW_SPEED;
  endproperty
  a_swreset: assert property (p_swreset) else $error("soft reset");
  property p_lowspd;
    w && REG_ADDR == 8'h30 && !REG_WDATA[7] |=>
      LOW_SPEED == $past(REG_WDATA[10]);
  endproperty
  a_lowspd: assert property (p_lowspd) else $error("low speed");
  property p_stby;
    w && REG_ADDR == 8'h31 |=> STANDBY_BOTH == $past(REG_WDATA[1]);
  endproperty
  a_stby: assert property (p_stby) else $error("standby");
  property p_global;
    w && REG_ADDR == 8'h31 |=> GLOBAL_PD == ($past(REG_WDATA[11:8]) == 4'hc);
  endproperty
  a_global: assert property (p_global) else $error("power down");
  property p_lvds;
    w && REG_ADDR == 8'h32 |=> LVDS_MODE == $past(REG_WDATA[7]);
  endproperty
  a_lvds: assert property (p_lvds) else $error("interface");
  property p_fmt;
    w && REG_ADDR == 8'h33 |=> TWOS_COMP == ($past(REG_WDATA[2:1]) == 2'h2);
  endproperty
  a_fmt: assert property (p_fmt) else $error("data format");
  property p_pat;
    w && REG_ADDR == 8'h34 |=> CUSTOM_PATTERN[13:8] == $past(REG_WDATA[5:0]);
  endproperty
  a_pat: assert property (p_pat) else $error("pattern");
  property p_wrbusy;
    w && REG_ADDR[7:3] == 5'h06 |=> CFG_BUSY;
  endproperty
  a_wrbusy: assert property (p_wrbusy) else $error("no update");
  property p_frame;
    $fell(CFG_SEN_N) |-> CFG_BUSY && !CFG_SCLK ##[1:8] $rose(CFG_SCLK);
  endproperty
  a_frame: assert property (p_frame) else $error("frame start");
  c_frame: cover property ($fell(CFG_SEN_N));
  c_reset: cover property (w && REG_ADDR == 8'h30 && REG_WDATA[7]);
  c_global: cover property (GLOBAL_PD);
endmodule
bind adccfg_bank adccfg_bank_props adccfg_bank_props_inst
(
  .MCLK, .RST, .CE, .REG_ADDR, .REG_WR, .REG_WDATA, .CFG_SCLK, .CFG_SEN_N,
  .CFG_BUSY, .LOW_SPEED, .STANDBY_BOTH, .GLOBAL_PD, .LVDS_MODE, .TWOS_COMP,
  .FINE_GAIN, .CUSTOM_PATTERN
);

// file: adccfg_bank_tb_top.sv
// self-checking bench for the converter configuration bank
`include "adccfg_map.svh"
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp); \
    end \
  end
module adccfg_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import adccfg_pkg::*;
  logic MCLK, RST, CE, REG_WR, REG_RD, CFG_SCLK, CFG_SEN_N, CFG_SDATA;
  logic CFG_BUSY, SERIAL_READBACK_EN, LOW_SPEED, STANDBY_BOTH, PWR_PIN_CTRL;
  logic PWR_NORMAL, OUT_OFF_A, OUT_OFF_B, GLOBAL_PD, STBY_A, STBY_B;
  logic LVDS_MODE, TWOS_COMP, OFFSET_BIN, INDEP_CTRL, OFS_EN_A, OFS_EN_B;
  logic [1:0]   REF_SEL;
  logic [2:0]   TEST_MODE;
  logic [3:0]   COARSE_A, COARSE_B;
  logic [4:0]   FALL_SHIFT, RISE_SHIFT, TC_LOG2_A, TC_LOG2_B;
  logic [5:0]   PEDESTAL;
  logic [6:0]   FINE_GAIN;
  logic [7:0]   REG_ADDR;
  logic [13:0]  CUSTOM_PATTERN;
  adccfg_word_t REG_WDATA, REG_RDATA;
  adccfg_word_t conv_regs [8];
  int           conv_frames, conv_bad;
  int           err_total = 0;
  int           cmp_count = 0;
  // short serial clock keeps each update frame at 48 cycles
  adccfg_bank #(.SCLK_HALF(8'h01)) adccfg_bank_inst
  (
    .MCLK, .RST, .CE, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA,
    .CFG_SCLK, .CFG_SEN_N, .CFG_SDATA, .CFG_BUSY, .SERIAL_READBACK_EN,
    .LOW_SPEED, .STANDBY_BOTH, .REF_SEL, .PWR_PIN_CTRL, .PWR_NORMAL,
    .OUT_OFF_A, .OUT_OFF_B, .GLOBAL_PD, .STBY_A, .STBY_B, .FALL_SHIFT,
    .RISE_SHIFT, .LVDS_MODE, .TWOS_COMP, .OFFSET_BIN, .INDEP_CTRL,
    .OFS_EN_A, .OFS_EN_B, .TC_LOG2_A, .TC_LOG2_B, .COARSE_A, .COARSE_B,
    .FINE_GAIN, .TEST_MODE, .CUSTOM_PATTERN, .PEDESTAL
  );
  adccfg_conv_model adccfg_conv_model_inst
  (
    .sclk(CFG_SCLK), .sen_n(CFG_SEN_N), .sdata(CFG_SDATA),
    .regs(conv_regs), .frames(conv_frames), .bad(conv_bad)
  );
  initial
  begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end
  task automatic wr(input logic [7:0] a, input adccfg_word_t d);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input adccfg_word_t e);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    @(negedge MCLK);
    `CHK(REG_RDATA, e)
  endtask
  // bounded wait for every pending update frame to leave
  task automatic idle();
    int i;
    i = 0;
    @(negedge MCLK);
    while (CFG_BUSY !== 1'b0 && i < 2000)
    begin
      @(negedge MCLK);
      i++;
    end
    `CHK(CFG_BUSY, 1'b0)
  endtask
  function automatic logic [4:0] sh(input logic [2:0] c);
    return c == 3'h5 ? 5'h04 : c == 3'h6 ? 5'h1a : c == 3'h7 ? 5'h1c : 5'h00;
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge MCLK);
    err_total++;
    give_verdict();
  end
  initial
  begin : main
    int i;
    adccfg_word_t m [8];
    logic [3:0] pc [8];
    logic [6:0] pw [8];
    m = '{`ADCCFG_MASK0 & 16'hff7f, `ADCCFG_MASK1, `ADCCFG_MASK2,
          `ADCCFG_MASK3, `ADCCFG_MASK4, `ADCCFG_MASK5, `ADCCFG_MASK6,
          `ADCCFG_MASK7};
    pc = '{4'h0, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he};
    pw = '{7'h40, 7'h20, 7'h08, 7'h10, 7'h18, 7'h04, 7'h01, 7'h02};
    RST = 1'b1;
    CE = 1'b1;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 8'h00;
    REG_WDATA = 16'h0000;
    repeat (20) @(posedge MCLK);
    RST <= 1'b0;
    for (i = 0; i < 9; i++)
      rd(8'h30 + i[7:0], 16'h0000);
    `CHK(PWR_PIN_CTRL, 1'b1)
    $display("test reset values done");
    // all ones everywhere except the soft reset bit of register 0; reserved places must read back zero
    for (i = 0; i < 8; i++)
      wr(8'h30 + i[7:0], i == 0 ? 16'hff7f : 16'hffff);
    for (i = 0; i < 8; i++)
      rd(8'h30 + i[7:0], m[i]);
    idle();
    for (i = 0; i < 8; i++)
      `CHK(conv_regs[i], m[i])
    `CHK({LOW_SPEED, STANDBY_BOTH, LVDS_MODE, OFFSET_BIN, INDEP_CTRL,
      OFS_EN_A, OFS_EN_B}, 7'h7f)
    `CHK({TC_LOG2_A, TC_LOG2_B, COARSE_A, COARSE_B},
      {5'h1d, 5'h1d, 4'hc, 4'hc})
    `CHK({SERIAL_READBACK_EN, REF_SEL}, 3'h7)
    `CHK({FINE_GAIN, TEST_MODE, CUSTOM_PATTERN, PEDESTAL},
      {7'h7f, 3'h7, 14'h3fff, 6'h3f})
    $display("test all ones done");
    for (i = 0; i < 8; i++)
    begin
      wr(8'h31, {4'h0, pc[i], 8'h00});
      @(negedge MCLK);
      `CHK({PWR_PIN_CTRL, PWR_NORMAL, OUT_OFF_A, OUT_OFF_B, GLOBAL_PD,
        STBY_A, STBY_B}, pw[i])
    end
    $display("test power modes done");
    for (i = 0; i < 8; i++)
    begin
      wr(8'h32, {i[2:0], i[2:0], 10'h000});
      wr(8'h33, {13'h0000, i[1:0], 1'b0});
      @(negedge MCLK);
      `CHK({FALL_SHIFT, RISE_SHIFT}, {2{sh(i[2:0])}})
      `CHK({TWOS_COMP, OFFSET_BIN}, {i[1:0] == 2'h2, i[1:0] == 2'h3})
    end
    $display("test edges and formats done");
    wr(8'h35, 16'h00cb);
    wr(8'h37, 16'h0000);
    wr(8'h34, 16'h4000);
    @(negedge MCLK);
    `CHK({TC_LOG2_A, COARSE_A, TC_LOG2_B, COARSE_B, OFS_EN_B},
      {5'h1d, 4'hc, 5'h12, 4'h0, 1'b1})
    wr(8'h33, 16'h0040);
    @(negedge MCLK);
    `CHK({INDEP_CTRL, OFS_EN_B}, 2'h2)
    $display("test channel control done");
    idle();
    wr(8'h36, 16'h2105);
    wr(8'h30, 16'h0480);
    @(negedge MCLK);
    `CHK({COARSE_A, TEST_MODE, PEDESTAL, OFS_EN_A}, 14'h0000)
    rd(8'h30, 16'h0000);
    idle();
    `CHK(conv_regs[0], 16'h0080)
    `CHK(conv_bad, 0)
    $display("test soft reset done");
    // a write while the enable is low must leave no trace
    @(posedge MCLK);
    CE <= 1'b0;
    wr(8'h36, 16'h0003);
    CE <= 1'b1;
    rd(8'h36, 16'h0000);
    `CHK(TEST_MODE, 3'h0)
    `CHK(CFG_BUSY, 1'b0)
    $display("test clock enable done");
    give_verdict();
  end
endmodule
